//--- design/sfd_decoder.sv
// Serial flash instruction decoder: framing, opcode decode, read streaming
// How it works
// R1 - Host sends write enable before any program or erase, and write enable or 50h before a status write.
// R2 - A falling chip select starts framing of a fresh instruction.
// R3 - Input bits sampled on rising serial clock, most significant bit first.
// R4 - Opcode, address, dummy and data cycles are eight bits each.
// R5 - Host frames instructions with chip select; reads end when it rises.
// R6 - Chip select rising mid-byte aborts the instruction, back to standby.
// R7 - 03h reads: three address bytes, no dummy, streamed data.
// R8 - 0Bh reads: three address bytes, one dummy byte, streamed data.
// R9 - Read pointer increments per byte and wraps from top to zero.
// R10 - Host keeps chip select low through a whole read.
// R11 - 20h erases a 4 KByte sector chosen by address bits down to 12.
// R12 - 52h erases a 32 KByte block chosen by address bits down to 15.
// R13 - D8h erases a 64 KByte block chosen by address bits down to 16.
// R14 - 60h or C7h erases the whole array, no address or data.
// R15 - 02h programs one byte after three address bytes.
// R16 - ADh word program; continuations carry two data bytes, even then odd.
// R17 - 05h streams the status byte until chip select rises.
// R18 - Decodes 06h, 04h, 50h, and 01h with one data byte.
// R19 - 70h shows ready or busy on output in word mode; 80h cancels it.
// R20 - 90h/ABh give maker or part code by address bit 0; 9Fh gives ID bytes.
// R21 - Address bits above the array size are dropped.
// R22 - Program and erase commands are rejected while the write latch is clear.
// R23 - In word mode only ADh, 05h and 04h are accepted.
// R24 - Status bit 0 shows the engine busy flag.
// R25 - Output data shifts out MSB first, changing on falling serial clock.
module sfd_decoder #(
  parameter logic [7:0]  MAKER_ID = 8'h5a,      // Arbitrary value
  parameter logic [7:0]  PART_ID  = 8'h3c,      // Arbitrary value
  parameter logic [23:0] STD_ID   = 24'h5a_3c_01 // Arbitrary value
) (
  input  wire logic                          CLOCK,
  input  wire logic                          RST,
  input  wire logic                          CE_N,
  input  wire logic                          SCK,
  input  wire logic                          SI,
  input  wire logic                          BUSY,
  input  wire logic [7:0]                    STAT_BITS,
  input  wire logic [7:0]                    MEM_DATA,
  output logic                               SO,
  output logic                               SO_OE,
  output logic [sfd_pkg::ADDR_W-1:0]         MEM_ADDR,
  output sfd_pkg::sfd_req_t                  OP_REQ,
  output logic                               WRITE_LATCH_FLAG,
  output logic                               AAI_MODE,
  output logic                               READY_BUSY_EN
);
  localparam int AW = sfd_pkg::ADDR_W;

  // Sign-in of pins
  logic [2:0] pins_s;
  logic       ce_s;
  logic       sck_s;
  logic       si_s;
  logic       ce_d_ff;
  logic       sck_d_ff;

  sfd_sync #(.W(sfd_pkg::SYNC_W), .RST_VAL(sfd_pkg::SYNC_IDLE)) u_sync (
    .clk      (CLOCK),
    .rst      (RST),
    .async_in ({CE_N, SCK, SI}),
    .sync_out (pins_s)
  );

  assign ce_s  = pins_s[2];
  assign sck_s = pins_s[1];
  assign si_s  = pins_s[0];

  // Edge finders on synchronised pins
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ce_d_ff  <= 1'b1;
      sck_d_ff <= 1'b0;
    end else begin
      ce_d_ff  <= ce_s;
      sck_d_ff <= sck_s;
    end
  end

  wire logic ce_fall  = ce_d_ff & ~ce_s;
  wire logic ce_rise  = ~ce_d_ff & ce_s;
  wire logic sck_rise = ~sck_d_ff & sck_s & ~ce_s;
  wire logic sck_fall = sck_d_ff & ~sck_s & ~ce_s;

  // Framing and command state
  sfd_pkg::sfd_state_t state_ff;
  logic [2:0]          bit_ff;
  logic [1:0]          byte_ff;
  logic [6:0]          shift_ff;
  logic [7:0]          op_ff;
  logic [AW-1:0]       addr_ff;
  logic [15:0]         data_ff;
  logic                pend_ff;
  logic                wel_ff;
  logic                aai_ff;
  logic                unlk_ff;
  logic                rbe_ff;
  logic [1:0]          id_ff;
  sfd_pkg::sfd_req_t   req_ff;

  // Base address of an erase granule
  function automatic logic [AW-1:0] granule(input logic [AW-1:0] a, input int lsb);
    granule = a & ~((AW'(1) << lsb) - AW'(1));
  endfunction : granule

  // Byte assembly, MSB first
  wire logic [7:0] in_byte   = {shift_ff, si_s};                          // R3
  wire logic       byte_done = sck_rise && (bit_ff == sfd_pkg::LAST_BIT); // R4
  wire logic       counting  = (state_ff == sfd_pkg::SFD_OPCODE) ||
                               (state_ff == sfd_pkg::SFD_ADDR) ||
                               (state_ff == sfd_pkg::SFD_DUMMY) ||
                               (state_ff == sfd_pkg::SFD_DIN) ||
                               (state_ff == sfd_pkg::SFD_DOUT);

  // Opcode classes
  wire logic is_write_op = (in_byte == sfd_pkg::OP_SECT_ERASE) ||
                           (in_byte == sfd_pkg::OP_BLK32) ||
                           (in_byte == sfd_pkg::OP_BLK64) ||
                           (in_byte == sfd_pkg::OP_BYTE_PROG) ||
                           (in_byte == sfd_pkg::OP_AAI) ||
                           (in_byte == sfd_pkg::OP_CHIP_A) ||
                           (in_byte == sfd_pkg::OP_CHIP_B);
  wire logic aai_legal   = (in_byte == sfd_pkg::OP_AAI) ||
                           (in_byte == sfd_pkg::OP_STAT_RD) ||
                           (in_byte == sfd_pkg::OP_LATCH_CLR);               // R23
  wire logic write_ok    = wel_ff && !BUSY;                                  // R22
  wire logic addr_op     = (in_byte == sfd_pkg::OP_READ) ||
                           (in_byte == sfd_pkg::OP_FAST_READ) ||
                           (in_byte == sfd_pkg::OP_ID_A) ||
                           (in_byte == sfd_pkg::OP_ID_B) ||
                           (in_byte == sfd_pkg::OP_SECT_ERASE) ||
                           (in_byte == sfd_pkg::OP_BLK32) ||
                           (in_byte == sfd_pkg::OP_BLK64) ||
                           (in_byte == sfd_pkg::OP_BYTE_PROG) ||
                           (in_byte == sfd_pkg::OP_AAI && !aai_ff);
  wire logic plain_op    = (in_byte == sfd_pkg::OP_LATCH_SET) ||
                           (in_byte == sfd_pkg::OP_LATCH_CLR) ||
                           (in_byte == sfd_pkg::OP_STAT_UNLK) ||
                           (in_byte == sfd_pkg::OP_BUSY_EN) ||
                           (in_byte == sfd_pkg::OP_BUSY_DIS) ||
                           (in_byte == sfd_pkg::OP_CHIP_A) ||
                           (in_byte == sfd_pkg::OP_CHIP_B);                  // R14 R18 R19
  wire logic is_read_op  = (op_ff == sfd_pkg::OP_READ) ||
                           (op_ff == sfd_pkg::OP_FAST_READ);
  wire logic top_word    = &addr_ff[AW-1:1];

  // Next address pointer: shifted in, advanced per read byte, or next word
  wire logic [AW-1:0] addr_shift = {addr_ff[AW-9:0], in_byte};               // R21
  wire logic [AW-1:0] addr_inc   = AW'(addr_ff + AW'(1));                    // R9
  wire logic [AW-1:0] word_next  = AW'({addr_ff[AW-1:1], 1'b0} + AW'(2));    // R16

  // Status byte and outgoing byte select
  wire logic [7:0] status_byte = {STAT_BITS[7], aai_ff, STAT_BITS[5:2], wel_ff, BUSY}; // R24
  wire logic [7:0] std_byte    = (id_ff == 2'h0) ? STD_ID[23:16] :
                                 (id_ff == 2'h1) ? STD_ID[15:8] : STD_ID[7:0];
  wire logic [7:0] out_byte    =
      (op_ff == sfd_pkg::OP_STAT_RD) ? status_byte :                         // R17
      (op_ff == sfd_pkg::OP_STD_ID)  ? std_byte :                            // R20
      (op_ff == sfd_pkg::OP_ID_A || op_ff == sfd_pkg::OP_ID_B) ?
          (addr_ff[0] ? PART_ID : MAKER_ID) :                                // R20
      MEM_DATA;

  // Framing state machine
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_ff <= sfd_pkg::SFD_IDLE;
      bit_ff   <= 3'h0;
      byte_ff  <= 2'h0;
      shift_ff <= 7'h00;
      op_ff    <= 8'h00;
      addr_ff  <= '0;
      data_ff  <= 16'h0000;
      pend_ff  <= 1'b0;
      id_ff    <= 2'h0;
    end else if (ce_fall) begin
      state_ff <= sfd_pkg::SFD_OPCODE;                                       // R2
      bit_ff   <= 3'h0;
      byte_ff  <= 2'h0;
      pend_ff  <= 1'b0;
      id_ff    <= 2'h0;
    end else if (ce_rise) begin
      state_ff <= sfd_pkg::SFD_IDLE;                                         // R6
      bit_ff   <= 3'h0;
      pend_ff  <= 1'b0;
      if (pend_ff && op_ff == sfd_pkg::OP_AAI && !top_word) begin
        addr_ff <= word_next;                                                // R16
      end
    end else if (sck_rise && counting) begin
      bit_ff   <= 3'(bit_ff + 3'h1);                                         // R4
      shift_ff <= in_byte[6:0];                                              // R3
      if (byte_done) begin
        unique case (state_ff)
          sfd_pkg::SFD_OPCODE: begin
            op_ff   <= in_byte;
            byte_ff <= 2'h0;
            if (aai_ff && !aai_legal) begin
              state_ff <= sfd_pkg::SFD_WAIT;                                 // R23
            end else if (is_write_op && !write_ok) begin
              state_ff <= sfd_pkg::SFD_WAIT;                                 // R22
            end else if (addr_op) begin
              state_ff <= sfd_pkg::SFD_ADDR;                                 // R7 R8 R11 R15
            end else if (in_byte == sfd_pkg::OP_AAI) begin
              state_ff <= sfd_pkg::SFD_DIN;                                  // R16
            end else if (in_byte == sfd_pkg::OP_STAT_RD ||
                         in_byte == sfd_pkg::OP_STD_ID) begin
              state_ff <= sfd_pkg::SFD_DOUT;                                 // R17 R20
            end else if (in_byte == sfd_pkg::OP_STAT_WR) begin
              state_ff <= (wel_ff || unlk_ff) ? sfd_pkg::SFD_DIN : sfd_pkg::SFD_WAIT; // R18
            end else begin
              state_ff <= sfd_pkg::SFD_WAIT;
              pend_ff  <= plain_op;
            end
          end
          sfd_pkg::SFD_ADDR: begin
            addr_ff <= addr_shift;
            byte_ff <= 2'(byte_ff + 2'h1);
            if (byte_ff == sfd_pkg::LAST_ADDR) begin
              byte_ff <= 2'h0;
              if (op_ff == sfd_pkg::OP_FAST_READ) begin
                state_ff <= sfd_pkg::SFD_DUMMY;                              // R8
              end else if (op_ff == sfd_pkg::OP_READ || op_ff == sfd_pkg::OP_ID_A ||
                           op_ff == sfd_pkg::OP_ID_B) begin
                state_ff <= sfd_pkg::SFD_DOUT;                               // R7 R20
              end else if (op_ff == sfd_pkg::OP_BYTE_PROG || op_ff == sfd_pkg::OP_AAI) begin
                state_ff <= sfd_pkg::SFD_DIN;                                // R15 R16
              end else begin
                state_ff <= sfd_pkg::SFD_WAIT;                               // R11 R12 R13
                pend_ff  <= 1'b1;
              end
            end
          end
          sfd_pkg::SFD_DUMMY: state_ff <= sfd_pkg::SFD_DOUT;                 // R8
          sfd_pkg::SFD_DIN: begin
            data_ff <= {data_ff[7:0], in_byte};
            byte_ff <= 2'(byte_ff + 2'h1);
            if (op_ff != sfd_pkg::OP_AAI || byte_ff != 2'h0) begin
              state_ff <= sfd_pkg::SFD_WAIT;                                 // R15 R16 R18
              pend_ff  <= 1'b1;
            end
          end
          sfd_pkg::SFD_DOUT: begin
            if (is_read_op) begin
              addr_ff <= addr_inc;                                           // R9
            end
            id_ff <= (id_ff == sfd_pkg::LAST_STDID) ? 2'h0 : 2'(id_ff + 2'h1);
          end
          default: state_ff <= sfd_pkg::SFD_WAIT;
        endcase
      end
    end
  end

  // Execution at the closing chip select: latches and engine requests
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wel_ff  <= 1'b0;
      aai_ff  <= 1'b0;
      unlk_ff <= 1'b0;
      rbe_ff  <= 1'b0;
      req_ff  <= '0;
    end else begin
      req_ff.valid <= 1'b0;
      if (ce_rise && pend_ff && bit_ff == 3'h0) begin                        // R6
        req_ff.addr  <= addr_ff;
        req_ff.data  <= data_ff;
        req_ff.kind  <= sfd_pkg::SFD_OP_NONE;
        unique case (op_ff)
          sfd_pkg::OP_LATCH_SET: wel_ff <= 1'b1;                             // R18
          sfd_pkg::OP_LATCH_CLR: begin
            wel_ff <= 1'b0;                                                  // R18
            aai_ff <= 1'b0;
          end
          sfd_pkg::OP_STAT_UNLK: unlk_ff <= 1'b1;
          sfd_pkg::OP_BUSY_EN:   rbe_ff  <= 1'b1;                            // R19
          sfd_pkg::OP_BUSY_DIS:  rbe_ff  <= 1'b0;                            // R19
          sfd_pkg::OP_STAT_WR: begin
            req_ff.valid <= 1'b1;
            req_ff.kind  <= sfd_pkg::SFD_OP_STAT;
            req_ff.data  <= {8'h00, data_ff[7:0]};
            wel_ff       <= 1'b0;
            unlk_ff      <= 1'b0;
          end
          sfd_pkg::OP_BYTE_PROG: begin
            req_ff.valid <= 1'b1;
            req_ff.kind  <= sfd_pkg::SFD_OP_BYTE;                            // R15
            req_ff.data  <= {8'h00, data_ff[7:0]};
            wel_ff       <= 1'b0;
          end
          sfd_pkg::OP_AAI: begin
            req_ff.valid <= 1'b1;
            req_ff.kind  <= sfd_pkg::SFD_OP_WORD;                            // R16
            req_ff.addr  <= {addr_ff[AW-1:1], 1'b0};
            aai_ff       <= !top_word;
            wel_ff       <= !top_word;
          end
          sfd_pkg::OP_SECT_ERASE: begin
            req_ff.valid <= 1'b1;
            req_ff.kind  <= sfd_pkg::SFD_OP_SECT;
            req_ff.addr  <= granule(addr_ff, sfd_pkg::SECT_LSB);             // R11
            wel_ff       <= 1'b0;
          end
          sfd_pkg::OP_BLK32: begin
            req_ff.valid <= 1'b1;
            req_ff.kind  <= sfd_pkg::SFD_OP_BLK32;
            req_ff.addr  <= granule(addr_ff, sfd_pkg::BLK32_LSB);            // R12
            wel_ff       <= 1'b0;
          end
          sfd_pkg::OP_BLK64: begin
            req_ff.valid <= 1'b1;
            req_ff.kind  <= sfd_pkg::SFD_OP_BLK64;
            req_ff.addr  <= granule(addr_ff, sfd_pkg::BLK64_LSB);            // R13
            wel_ff       <= 1'b0;
          end
          sfd_pkg::OP_CHIP_A, sfd_pkg::OP_CHIP_B: begin
            req_ff.valid <= 1'b1;
            req_ff.kind  <= sfd_pkg::SFD_OP_CHIP;                            // R14
            req_ff.addr  <= '0;
            wel_ff       <= 1'b0;
          end
          default: req_ff.valid <= 1'b0;
        endcase
      end
    end
  end

  // Serial output path
  logic shift_bit;
  wire logic out_load = (bit_ff == 3'h0);
  wire logic in_dout  = (state_ff == sfd_pkg::SFD_DOUT);
  wire logic rb_mode  = rbe_ff && aai_ff && !ce_s && !in_dout;               // R19

  sfd_shift_out u_shift (
    .clk     (CLOCK),
    .rst     (RST),
    .fall    (sck_fall && in_dout),                                          // R25
    .load    (out_load),
    .byte_in (out_byte),
    .bit_out (shift_bit)
  );

  // Registered pin and status outputs
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SO       <= 1'b0;
      SO_OE    <= 1'b0;
      MEM_ADDR <= '0;
    end else begin
      SO       <= rb_mode ? !BUSY : shift_bit;                               // R19 R25
      SO_OE    <= !ce_s && (in_dout || rb_mode);
      MEM_ADDR <= addr_ff;
    end
  end

  assign OP_REQ           = req_ff;
  assign WRITE_LATCH_FLAG = wel_ff;
  assign AAI_MODE         = aai_ff;
  assign READY_BUSY_EN    = rbe_ff;

  // Checks
  a_frame_start: assert property (@(posedge CLOCK) disable iff (RST) // R2
    ce_fall |=> state_ff == sfd_pkg::SFD_OPCODE && bit_ff == 3'h0)
    else $error("frame did not restart on chip select fall");
  a_msb_first: assert property (@(posedge CLOCK) disable iff (RST) // R3
    byte_done && state_ff == sfd_pkg::SFD_OPCODE && !ce_fall && !ce_rise
    |=> op_ff == {$past(shift_ff), $past(si_s)})
    else $error("opcode not assembled msb first");
  a_bit_count: assert property (@(posedge CLOCK) disable iff (RST) // R4
    sck_rise && counting && !ce_fall && !ce_rise |=> bit_ff == 3'($past(bit_ff) + 3'h1))
    else $error("bit counter did not advance");
  a_abort_mid: assert property (@(posedge CLOCK) disable iff (RST) // R6
    ce_rise && bit_ff != 3'h0 |=> state_ff == sfd_pkg::SFD_IDLE && !req_ff.valid)
    else $error("partial byte was not aborted");
  a_read_wrap: assert property (@(posedge CLOCK) disable iff (RST) // R9
    byte_done && in_dout && is_read_op && !ce_fall && !ce_rise
    |=> addr_ff == AW'($past(addr_ff) + AW'(1)))
    else $error("read pointer did not advance");
  a_sector_base: assert property (@(posedge CLOCK) disable iff (RST) // R11
    req_ff.valid && req_ff.kind == sfd_pkg::SFD_OP_SECT |-> req_ff.addr[11:0] == 12'h000)
    else $error("sector erase address not aligned");
  a_block_base: assert property (@(posedge CLOCK) disable iff (RST) // R13
    req_ff.valid && req_ff.kind == sfd_pkg::SFD_OP_BLK64 |-> req_ff.addr[15:0] == 16'h0000)
    else $error("block erase address not aligned");
  a_latch_gate: assert property (@(posedge CLOCK) disable iff (RST) // R22
    req_ff.valid && req_ff.kind != sfd_pkg::SFD_OP_STAT |-> $past(wel_ff))
    else $error("write issued with latch clear");
  a_word_filter: assert property (@(posedge CLOCK) disable iff (RST) // R23
    byte_done && state_ff == sfd_pkg::SFD_OPCODE && aai_ff && !aai_legal && !ce_fall && !ce_rise
    |=> state_ff == sfd_pkg::SFD_WAIT)
    else $error("illegal opcode accepted in word mode");
endmodule : sfd_decoder

//--- design/sfd_pkg.sv
// Shared constants and types for the serial flash instruction decoder
package sfd_pkg;
  localparam int ADDR_W = 19;  // 512 KByte array, top address 7ffff
  localparam int SYNC_W = 3;   // Chip select, serial clock, serial input
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 3'h4;  // Pins at rest: chip select high

  // Opcodes
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_FAST_READ  = 8'h0b;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK32      = 8'h52;
  localparam logic [7:0] OP_BLK64      = 8'hd8;
  localparam logic [7:0] OP_CHIP_A     = 8'h60;
  localparam logic [7:0] OP_CHIP_B     = 8'hc7;
  localparam logic [7:0] OP_BYTE_PROG  = 8'h02;
  localparam logic [7:0] OP_AAI        = 8'had;
  localparam logic [7:0] OP_STAT_RD    = 8'h05;
  localparam logic [7:0] OP_STAT_UNLK  = 8'h50;
  localparam logic [7:0] OP_STAT_WR    = 8'h01;
  localparam logic [7:0] OP_LATCH_SET  = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR  = 8'h04;
  localparam logic [7:0] OP_ID_A       = 8'h90;
  localparam logic [7:0] OP_ID_B       = 8'hab;
  localparam logic [7:0] OP_STD_ID     = 8'h9f;
  localparam logic [7:0] OP_BUSY_EN    = 8'h70;
  localparam logic [7:0] OP_BUSY_DIS   = 8'h80;

  // Framing counts
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [1:0] LAST_ADDR  = 2'h2;
  localparam logic [1:0] LAST_STDID = 2'h2;

  // Erase granule address LSBs
  localparam int SECT_LSB  = 12;
  localparam int BLK32_LSB = 15;
  localparam int BLK64_LSB = 16;

  // Status byte field positions
  localparam int ST_BUSY = 0;
  localparam int ST_WEL  = 1;
  localparam int ST_AAI  = 6;

  // Operation handed to the array engine
  typedef enum logic [2:0] {
    SFD_OP_NONE  = 3'b000,
    SFD_OP_BYTE  = 3'b001,
    SFD_OP_WORD  = 3'b010,
    SFD_OP_SECT  = 3'b011,
    SFD_OP_BLK32 = 3'b100,
    SFD_OP_BLK64 = 3'b101,
    SFD_OP_CHIP  = 3'b110,
    SFD_OP_STAT  = 3'b111
  } sfd_kind_t;

  typedef struct packed {
    logic              valid;
    sfd_kind_t         kind;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
  } sfd_req_t;

  // Framing states
  typedef enum logic [2:0] {
    SFD_IDLE   = 3'b000,
    SFD_OPCODE = 3'b001,
    SFD_ADDR   = 3'b010,
    SFD_DUMMY  = 3'b011,
    SFD_DIN    = 3'b100,
    SFD_DOUT   = 3'b101,
    SFD_WAIT   = 3'b110
  } sfd_state_t;
endpackage : sfd_pkg

//--- design/sfd_shift_out.sv
// Byte serialiser for the serial output, MSB first on falling clock edges
module sfd_shift_out (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fall,
  input  wire logic       load,
  input  wire logic [7:0] byte_in,
  output logic            bit_out
);
  logic [6:0] rest_ff;

  // Load presents bit 7 at once, later falls walk down the byte
  always_ff @(posedge clk) begin
    if (rst) begin
      rest_ff <= 7'h00;
      bit_out <= 1'b0;
    end else if (fall && load) begin
      bit_out <= byte_in[7];
      rest_ff <= byte_in[6:0];
    end else if (fall) begin
      bit_out <= rest_ff[6];
      rest_ff <= {rest_ff[5:0], 1'b0};
    end
  end
endmodule : sfd_shift_out

//--- design/sfd_sync.sv
// Two-flop synchroniser for the serial bus pins
module sfd_sync #(
  parameter int           W       = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage; reset to the pins' idle levels
  // so that no false edge is seen once reset lets go
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff  <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : sfd_sync

//--- tb/sfd_host_model.sv
// Host serial bus master model for the decoder's link pins
module sfd_host_model (
  input  wire logic clk,
  output logic      ce_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ce_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // Wait n clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Select the device; the serial clock rests low between frames
  task automatic start();
    tick(1);
    ce_n = 1'b0;
    tick(4);
  endtask : start
  // Deselect; the data line flips since its value no longer means anything
  task automatic stop();
    tick(4);
    ce_n = 1'b1;
    si   = ~si;
    tick(12);
  endtask : stop
  // Shift n bits of d MSB first, capturing the output late in each high phase
  task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
    for (int i = 7; i > 7 - n; i--) begin
      si = d[i];
      tick(4);
      sck = 1'b1;
      tick(4);
      q[i] = so;
      sck = 1'b0;
    end
  endtask : xfer
endmodule : sfd_host_model

//--- tb/test_sfd_decoder.sv
// Self-checking bench for the serial flash instruction decoder
module test_sfd_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, ce_n, sck, si, so, oe, busy, write_latch_flag, auto_increment_word_program, rbe;
  logic [7:0] stat, mem, q;
  logic [18:0] maddr;
  logic [23:0] a;
  sfd_pkg::sfd_req_t req, got;
  logic [7:0] rd[4];
  logic [7:0] b[$];
  int fails, checks_done, nreq, n0, seed;
  logic [7:0] ops[6] = '{8'h20, 8'h52, 8'hd8, 8'h02, 8'h60, 8'hc7};
  int nb[6] = '{3, 3, 3, 4, 0, 0};
  int kd[6] = '{3, 4, 5, 1, 6, 6};
  int sh[4] = '{12, 15, 16, 0};
  // Array contents model
  function automatic logic [7:0] mem_f(input logic [18:0] x);
    return x[7:0] ^ {x[18:16], x[12:8]};
  endfunction : mem_f
  assign mem = mem_f(maddr);
  sfd_decoder DUT (.CLOCK(clk), .RST(rst), .CE_N(ce_n), .SCK(sck), .SI(si), .BUSY(busy),
    .STAT_BITS(stat), .MEM_DATA(mem), .SO(so), .SO_OE(oe), .MEM_ADDR(maddr), .OP_REQ(req),
    .WRITE_LATCH_FLAG(write_latch_flag), .AAI_MODE(auto_increment_word_program), .READY_BUSY_EN(rbe));
  sfd_host_model host (.clk(clk), .ce_n(ce_n), .sck(sck), .si(si), .so(so));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Keep the last request and count pulses
  always @(posedge clk) if (req.valid === 1'b1) begin
    got <= req;
    nreq <= nreq + 1;
  end
  task automatic chk(input string n, input logic [95:0] e, input logic [95:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One frame: send bytes (last one possibly cut short), then read nr bytes
  task automatic run(input logic [7:0] v[$], input int nr, input int lastn = 8);
    host.start();
    foreach (v[i]) host.xfer(v[i], (i == v.size() - 1) ? lastn : 8, q);
    for (int i = 0; i < nr; i++) host.xfer(~q, 8, rd[i]);
    if (nr > 0) chk("output enable", 1, oe);
    host.stop();
  endtask : run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  initial begin
    seed = 32'h0d7e;
    rst = 1'b1;
    busy = 1'b0;
    stat = $random(seed);
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    host.tick(3);
    a = 24'hfffffe;
    run({8'h03, a[23:16], a[15:8], a[7:0]}, 4);
    for (int i = 0; i < 4; i++) chk("read", mem_f(19'(a + i)), rd[i]);
    a = $random(seed);
    run({8'h0b, a[23:16], a[15:8], a[7:0], 8'h00}, 2);
    chk("fast read", {mem_f(a[18:0]), mem_f(19'(a + 1))}, {rd[0], rd[1]});
    busy = 1'b1;
    run({8'h05}, 2);
    chk("status", {2{stat[7], 1'b0, stat[5:2], 2'b01}}, {rd[0], rd[1]});
    busy = 1'b0;
    run({8'h90, 8'h00, 8'h00, 8'h00}, 2);
    chk("maker id", 16'h5a5a, {rd[0], rd[1]});
    run({8'hab, 8'h00, 8'h00, 8'h01}, 1);
    chk("part id", 8'h3c, rd[0]);
    run({8'h9f}, 4);
    chk("std id", 32'h5a3c015a, {rd[0], rd[1], rd[2], rd[3]});
    $display("test reads done");
    for (int i = 0; i < 6; i++) begin
      a = $random(seed);
      run({8'h06}, 0);
      chk("latch set", 1, write_latch_flag);
      b = {ops[i], a[23:16], a[15:8], a[7:0], a[7:0]};
      n0 = nreq;
      run(b[0:nb[i]], 0);
      chk("req count", n0 + 1, nreq);
      chk("req kind", kd[i], got.kind);
      if (i < 4) chk("req addr", a[18:0] >> sh[i] << sh[i], got.addr);
      chk("latch after", 0, write_latch_flag);
    end
    $display("test erase done");
    n0 = nreq;
    run({8'h20, 8'h00, 8'h10, 8'h00}, 0);
    busy = 1'b1;
    run({8'h06}, 0);
    run({8'h52, 8'h00, 8'h80, 8'h00}, 0);
    busy = 1'b0;
    run({8'h02, 8'h00, 8'h00, 8'h40, 8'h55}, 0, 5);
    chk("refused", n0, nreq);
    run({8'h04}, 0);
    chk("latch clear", 0, write_latch_flag);
    $display("test refuse done");
    a = $random(seed) & 24'h03fff0;
    run({8'h70}, 0);
    chk("rb enable", 1, rbe);
    run({8'h06}, 0);
    n0 = nreq;
    run({8'had, a[23:16], a[15:8], a[7:0], 8'h3c, 8'ha5}, 0);
    chk("word", {n0 + 1, 3'h2, a[18:0], 16'h3ca5}, {nreq, got.kind, got.addr, got.data});
    run({8'had, 8'h12, 8'h34}, 0);
    chk("word 2", {n0 + 2, a[18:0] + 19'h2, 16'h1234}, {nreq, got.addr, got.data});
    chk("ready out", 8'hff, q);
    busy = 1'b1;
    run({8'h20, a[23:16], a[15:8], a[7:0]}, 0);
    chk("busy out", 8'h00, q);
    busy = 1'b0;
    chk("word only", {n0 + 2, 1'b1}, {nreq, auto_increment_word_program});
    run({8'h04}, 0);
    run({8'h80}, 0);
    chk("word end", 3'b000, {auto_increment_word_program, write_latch_flag, rbe});
    run({8'h50}, 0);
    run({8'h01, 8'h9c}, 0);
    chk("stat wr", {n0 + 3, 3'h7, 8'h9c}, {nreq, got.kind, got.data[7:0]});
    $display("test word done");
    report_and_stop();
  end
endmodule : test_sfd_decoder
